// >>> core/fuc_pkg.sv
// Purpose: shared constants for the fused micro-op split check
// Assumes: one core clock, operand presence flags from decode
// Notes:   source count fits in 3 bits (max 6)
package fuc_pkg;
   localparam int          FUC_CNT_W     = 3;
   localparam logic [2:0]  FUC_MAX_FUSED = 3'h3;
   localparam logic [2:0]  FUC_MEM_MAX   = 3'h2;
   localparam int          FUC_UOP_W     = 32;
   typedef enum logic [1:0] {
      FUC_IDLE,
      FUC_SECOND
   } fuc_state_t;
endpackage : fuc_pkg

// >>> core/fuc_split_check.sv
// Purpose: counts fused instruction sources and splits into two micro-ops when over three
// Assumes: decode gives operand presence flags and the two halves of a fused entry
// Notes:   one instruction accepted per cycle when idle; split costs one extra cycle
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// - split when counted sources exceed three
// - split entry becomes exactly two micro-ops
// - count base, index, src, dst, srcdst only
// - memory operand contributes at most two sources
// - scale and displacement never counted
// - index present implies base counted too
// - read-and-written register counts as two
module fuc_split_check
   import fuc_pkg::*;
#(
   parameter int UOP_W = FUC_UOP_W
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic             has_base_i,
   input  wire logic             has_index_i,
   input  wire logic             has_src_i,
   input  wire logic             has_dst_i,
   input  wire logic             has_srcdst_i,
   input  wire logic [UOP_W-1:0] fused_uop_i,
   input  wire logic [UOP_W-1:0] mem_uop_i,
   input  wire logic [UOP_W-1:0] op_uop_i,
   output logic                  out_valid_o,
   output logic [UOP_W-1:0]      out_uop_o,
   output logic                  out_split_o,
   output logic [FUC_CNT_W-1:0]  out_count_o
);
   //////////////////////////////////////////////////////////////////////////////////////
   // held parks the register half while the memory half is on the output
   typedef struct packed {
      fuc_state_t             st;
      logic                   rdy;
      logic                   vld;
      logic [UOP_W-1:0]       uop;
      logic                   split;
      logic [FUC_CNT_W-1:0]   cnt;
      logic [UOP_W-1:0]       held;
   } fuc_regs_t;

   fuc_regs_t r_q;
   fuc_regs_t r_d;
   logic [FUC_CNT_W-1:0] mem_cnt;
   logic [FUC_CNT_W-1:0] reg_cnt;
   logic [FUC_CNT_W-1:0] total;
   logic                 need_split;
   logic                 take;

   //////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      // index forces the base slot, so base-less indexed forms still cost two
      mem_cnt = has_index_i ? 3'h2 : {2'h0, has_base_i};
      if (mem_cnt > FUC_MEM_MAX) begin
         mem_cnt = FUC_MEM_MAX;
      end
      // srcdst weighs two because one register is both read and written
      reg_cnt = {2'h0, has_src_i} + {2'h0, has_dst_i} + {1'b0, has_srcdst_i, 1'b0};
      total      = mem_cnt + reg_cnt;
      need_split = total > FUC_MAX_FUSED;
      // ready is the only gate: nothing downstream pushes back
      take       = in_valid_i && r_q.rdy;
      r_d        = r_q;
      r_d.vld    = 1'b0;
      case (r_q.st)
         FUC_IDLE: begin
            if (take) begin
               r_d.vld   = 1'b1;
               r_d.cnt   = total;
               r_d.split = need_split;
               if (need_split) begin
                  r_d.uop  = mem_uop_i;
                  r_d.held = op_uop_i;
                  r_d.st   = FUC_SECOND;
                  r_d.rdy  = 1'b0;
               end else begin
                  r_d.uop = fused_uop_i;
               end
            end
         end
         FUC_SECOND: begin
            // second half leaves at once, so no other micro-op can slip between
            r_d.vld = 1'b1;
            r_d.uop = r_q.held;
            r_d.st  = FUC_IDLE;
            r_d.rdy = 1'b1;
         end
         default: begin
            r_d.st  = FUC_IDLE;
            r_d.rdy = 1'b1;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // ready leaves reset high so the first offer after release is taken
         r_q       <= '0;
         r_q.st    <= FUC_IDLE;
         r_q.rdy   <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   assign in_ready_o  = r_q.rdy;
   assign out_valid_o = r_q.vld;
   assign out_uop_o   = r_q.uop;
   assign out_split_o = r_q.split;
   assign out_count_o = r_q.cnt;

   //////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   // exact-count checks use hand-picked operand mixes so they stay independent of the adder; a_mem_two compares against reg_cnt
   a_split_over_three: assert property (
      take |=> (out_split_o == (out_count_o > 3'h3)))
      else $error("split flag disagrees with count");

   a_split_two_uops: assert property (
      (take && need_split)
      |=> (out_valid_o && !in_ready_o)
      ##1 (out_valid_o && in_ready_o)
      ##1 (!out_valid_o || $past(take)))
      else $error("split did not give exactly two micro-ops");

   a_count_max: assert property (
      take |=> out_count_o <= 3'h6)
      else $error("count out of range");

   a_mem_two: assert property (
      take |=> out_count_o <= ($past(reg_cnt) + 3'h2))
      else $error("memory operand counted above two");

   a_index_base: assert property (
      (take && has_index_i && !has_src_i && !has_dst_i && !has_srcdst_i) |=> out_count_o == 3'h2)
      else $error("index without base not counted as two");

   a_srcdst_two: assert property (
      (take && has_srcdst_i && !has_base_i && !has_index_i && !has_src_i && !has_dst_i)
      |=> out_count_o == 3'h2)
      else $error("src-dst register not counted as two");

   a_second_in_order: assert property (
      (take && need_split) |=> ##1 (out_valid_o && out_uop_o == $past(op_uop_i, 2)))
      else $error("second half missing or wrong");

   a_fused_passes: assert property (
      (take && !need_split) |=> (out_valid_o && out_uop_o == $past(fused_uop_i) && in_ready_o))
      else $error("fused entry not passed whole");

   a_base_only: assert property (
      (take && has_base_i && !has_index_i && !has_src_i && !has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h1 && !out_split_o))
      else $error("base-only address not counted as one");

   a_full_address: assert property (
      (take && has_base_i && has_index_i && !has_src_i && !has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h2))
      else $error("base and index counted above two");

   a_regs_only: assert property (
      (take && !has_base_i && !has_index_i && has_src_i && has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h2))
      else $error("source and destination not counted once each");

   a_empty_zero: assert property (
      (take && !has_base_i && !has_index_i && !has_src_i && !has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h0 && !out_split_o))
      else $error("operand-free entry counted as nonzero");

   a_all_six: assert property (
      (take && has_base_i && has_index_i && has_src_i && has_dst_i && has_srcdst_i)
      |=> (out_count_o == 3'h6 && out_split_o))
      else $error("full operand mix not counted as six");

   a_split_four: assert property (
      (take && !has_base_i && has_index_i && has_src_i && has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h4 && out_split_o))
      else $error("four-source entry kept fused");

   a_no_split_three: assert property (
      (take && has_base_i && !has_index_i && has_src_i && has_dst_i && !has_srcdst_i)
      |=> (out_count_o == 3'h3 && !out_split_o))
      else $error("three-source entry was split");

   a_first_half_mem: assert property (
      (take && need_split)
      |=> (out_uop_o == $past(mem_uop_i) && out_split_o && !in_ready_o))
      else $error("first half is not the memory micro-op");

   a_ready_one_low: assert property (
      !in_ready_o
      |=> in_ready_o)
      else $error("ready held low longer than one cycle");

   a_refuse_busy: assert property (
      (in_valid_i && !in_ready_o)
      |=> (out_uop_o == $past(op_uop_i, 2) && out_split_o && in_ready_o))
      else $error("offer taken while the second half was pending");

   a_hold_idle: assert property (
      (!take && r_q.st == FUC_IDLE)
      |=> (!out_valid_o && $stable(out_uop_o) && $stable(out_split_o) && $stable(out_count_o)))
      else $error("outputs moved without a take");

   // main scenarios: fused, split, split then next offer, refused offer, base-less index
   c_fused: cover property (take && !need_split);
   c_split: cover property (take && need_split);
   c_back_to_back: cover property (take && need_split ##2 take);
   c_refused: cover property (in_valid_i && !in_ready_o);
   c_index_no_base: cover property (take && has_index_i && !has_base_i);
endmodule : fuc_split_check

// >>> tb/fuc_alloc_sink.sv
// Purpose: allocation side model, counts micro-ops handed over
// Assumes: no backpressure exists toward the split check
// Notes:   count clears on reset
`timescale 1ns/1ps
module fuc_alloc_sink (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   input  wire logic valid_i,
   output int        count_o
);
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) count_o <= 0;
      else if (valid_i) count_o <= count_o + 1;
   end
endmodule : fuc_alloc_sink

// >>> tb/fuc_split_check_tb.sv
// Purpose: bench for the fused split check
// Assumes: sink counts every micro-op handed on
// Notes:   one table row per operand mix
`timescale 1ns/1ps
module fuc_split_check_tb;
   import fuc_pkg::*;
   logic        clk = 0, rst_n = 0, v = 0, ov, os, rdy;
   logic [4:0]  f = 0;
   logic [31:0] uo;
   logic [2:0]  oc;
   int          n, failures = 0, checks_done = 0;
   // {base,index,src,dst,srcdst, count, split}; rows above three feed splits on purpose
   localparam logic [8:0] ROWS [12] = '{9'h166, 9'h0e9, 9'h1e9, 9'h056,
      9'h139, 9'h1fd, 9'h000, 9'h014, 9'h084, 9'h102, 9'h184, 9'h064};
   initial forever #2 clk = ~clk;
   fuc_split_check u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .in_valid_i(v),
      .in_ready_o(rdy), .has_base_i(f[4]), .has_index_i(f[3]), .has_src_i(f[2]),
      .has_dst_i(f[1]), .has_srcdst_i(f[0]), .fused_uop_i({27'h0, f}),
      .mem_uop_i({27'h1, f}), .op_uop_i({27'h2, f}), .out_valid_o(ov),
      .out_uop_o(uo), .out_split_o(os), .out_count_o(oc));
   fuc_alloc_sink u_sink (.core_clk_i(clk), .reset_n_i(rst_n), .valid_i(ov), .count_o(n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic print_verdict;
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // one row per offer with an idle cycle between; t_stream offers back to back
   task automatic t_rows;
      foreach (ROWS[k]) begin
         @(posedge clk);
         v <= 1'b1;
         f <= ROWS[k][8:4];
         @(posedge clk);
         v <= 1'b0;
         #1;
         chk({ov, os, oc, rdy}, {1'b1, ROWS[k][0], ROWS[k][3:1], ~ROWS[k][0]});
         chk(uo, {26'h0, ROWS[k][0], ROWS[k][8:4]});
         if (ROWS[k][0]) begin
            @(posedge clk);
            #1;
            chk({ov, rdy, os, uo}, {3'b111, 27'h2, ROWS[k][8:4]});
         end
      end
      @(posedge clk);
      #1;
      chk(n, 32'h00000010);
   endtask : t_rows
   // split then fused offered back to back; the fused offer waits out the busy cycle
   task automatic t_stream;
      @(posedge clk);
      v <= 1'b1;
      f <= ROWS[1][8:4];
      @(posedge clk);
      f <= ROWS[0][8:4];
      #1;
      chk({ov, rdy, os, uo}, {3'b101, 27'h1, ROWS[1][8:4]});
      @(posedge clk);
      #1;
      chk({ov, rdy, os, uo}, {3'b111, 27'h2, ROWS[1][8:4]});
      @(posedge clk);
      v <= 1'b0;
      #1;
      chk({ov, os, oc, uo}, {2'b10, ROWS[0][3:1], 27'h0, ROWS[0][8:4]});
      @(posedge clk);
      #1;
      chk({ov, n}, {1'b0, 32'h00000013});
   endtask : t_stream
   task automatic t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk({rdy, ov, os, oc}, 6'h20);
      chk(uo, 32'h0);
      chk(n, 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      v <= 1'b1;
      f <= ROWS[8][8:4];
      @(posedge clk);
      v <= 1'b0;
      #1;
      chk({ov, os, oc, uo}, {2'b10, ROWS[8][3:1], 27'h0, ROWS[8][8:4]});
      @(posedge clk);
      #1;
      chk({ov, n}, {1'b0, 32'h00000001});
   endtask : t_reset
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_rows;
      t_stream;
      t_reset;
      print_verdict;
   end
   initial begin
      #4000;
      failures++;
      print_verdict;
   end
endmodule : fuc_split_check_tb
